// ---- design/ldfc_pkg.sv ----
// Constants and types for the laser driver fault and trim control block
// What this block does
// - Equalizer off means bypass, code ignored
// - Equalizer code decoded inversely, zeros strongest
// - Cross-point bit 7 is shift sign
// - Low seven bits give shift magnitude
// - Limiter bit 3 sign: one lowers bias
// - Limiter magnitude 000 none, 111 largest
// - High-current bit 0 selects wide range
// - Fault on monitor overvoltage or photodiode overcurrent
// - Fault when bias DAC more than halves
// - Enabled fault zeroes currents, latches fault output
// - Fault output low while disabled
// - Clean re-enable resumes after negate time
// - Persisting fault reasserts at once on re-enable
package ldfc_pkg;

    localparam logic [3:0] LDFC_OFS_EQ_ADJ = 4'h6;
    localparam logic [3:0] LDFC_OFS_CP_ADJ = 4'h7;
    localparam logic [3:0] LDFC_OFS_LIM_ADJ = 4'h8;
    localparam logic [3:0] LDFC_OFS_HMC = 4'h9;

    localparam logic [7:0] LDFC_RST_EQ_ADJ = 8'h00;
    localparam logic [7:0] LDFC_RST_CP_ADJ = 8'h00;
    localparam logic [7:0] LDFC_RST_LIM_ADJ = 8'h00;
    localparam logic [7:0] LDFC_RST_HMC = 8'h00;

    localparam int LDFC_CP_SIGN_BIT = 7;
    localparam int LDFC_LIM_SIGN_BIT = 3;
    localparam int LDFC_HMC_BIT = 0;

    localparam int LDFC_LATCH_RESET_CYC = 40;
    localparam int LDFC_NEGATE_CYC = 80;

    typedef enum {LDFC_OPER, LDFC_TRIPPED, LDFC_OFF, LDFC_WAKE} ldfc_state_e;

    typedef struct packed {
        logic eqBypass;
        logic [7:0] eqStrength;
        logic crossShiftPositive;
        logic [6:0] crossShiftMag;
        logic limiterLower;
        logic [2:0] limiterMag;
        logic wideModRange;
    } ldfc_trim_s;

endpackage : ldfc_pkg

// ---- design/ldfc_core.sv ----
// Trim decode and laser safety fault logic
`timescale 1ns/100ps
`default_nettype none
module ldfc_core import ldfc_pkg::*; #(
    parameter int LATCH_RESET_CYC = LDFC_LATCH_RESET_CYC,
    parameter int NEGATE_CYC = LDFC_NEGATE_CYC,
    parameter int DAC_W = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port from the serial interface
    input wire logic regWrEn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Control bits held elsewhere
    input wire logic equalizerOn,
    input wire logic faultShutdownEnable,
    input wire logic outputEnableBit,
    // Pins and comparators
    input wire logic disablePin,
    input wire logic biasMonitorOver,
    input wire logic photodiodeOver,
    // Bias DAC updates
    input wire logic biasDacUpdate,
    input wire logic [DAC_W-1:0] biasDacCode,
    // Outputs
    output ldfc_trim_s trim,
    output logic biasForceZero,
    output logic modForceZero,
    output logic faultOutput
);

    localparam int CNT_MAX = (LATCH_RESET_CYC > NEGATE_CYC) ? LATCH_RESET_CYC : NEGATE_CYC;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam logic [CNT_W-1:0] LATCH_LIM = CNT_W'(LATCH_RESET_CYC);
    localparam logic [CNT_W-1:0] NEGATE_LIM = CNT_W'(NEGATE_CYC);

    function automatic ldfc_trim_s decodeTrim(input logic eqOn, input logic [7:0] equalizer_adjust,
                                              input logic [7:0] cross_point_adjust, input logic [7:0] limAdj,
                                              input logic [7:0] hmc);
        ldfc_trim_s t;
        t.eqBypass = !eqOn;
        t.eqStrength = eqOn ? ~equalizer_adjust : 8'h00;
        t.crossShiftPositive = cross_point_adjust[LDFC_CP_SIGN_BIT];
        t.crossShiftMag = cross_point_adjust[6:0];
        t.limiterLower = limAdj[LDFC_LIM_SIGN_BIT];
        t.limiterMag = limAdj[2:0];
        t.wideModRange = hmc[LDFC_HMC_BIT];
        return t;
    endfunction : decodeTrim

    // Trim registers
    logic [7:0] equalizer_adjust_q;
    logic [7:0] cross_point_adjust_q;
    logic [7:0] limAdj_q;
    logic [7:0] hmc_q;
    logic [7:0] regRdData_q;
    logic [7:0] rdMux;
    ldfc_trim_s trim_q;
    ldfc_trim_s trim_d;

    assign rdMux = (regAddr == LDFC_OFS_EQ_ADJ) ? equalizer_adjust_q :
                   (regAddr == LDFC_OFS_CP_ADJ) ? cross_point_adjust_q :
                   (regAddr == LDFC_OFS_LIM_ADJ) ? limAdj_q :
                   (regAddr == LDFC_OFS_HMC) ? hmc_q : 8'h00;
    assign trim_d = decodeTrim(equalizerOn, equalizer_adjust_q, cross_point_adjust_q, limAdj_q, hmc_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            equalizer_adjust_q <= LDFC_RST_EQ_ADJ;
            cross_point_adjust_q <= LDFC_RST_CP_ADJ;
            limAdj_q <= LDFC_RST_LIM_ADJ;
            hmc_q <= LDFC_RST_HMC;
        end else if (regWrEn) begin
            if (regAddr == LDFC_OFS_EQ_ADJ) equalizer_adjust_q <= regWrData;
            if (regAddr == LDFC_OFS_CP_ADJ) cross_point_adjust_q <= regWrData;
            if (regAddr == LDFC_OFS_LIM_ADJ) limAdj_q <= regWrData;
            if (regAddr == LDFC_OFS_HMC) hmc_q <= regWrData;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regRdData_q <= 8'h00;
            trim_q <= '0;
        end else begin
            regRdData_q <= rdMux;
            trim_q <= trim_d;
        end
    end

    // Pin synchronisers, a change counts when stages two and three agree
    logic [2:0] disSync_q;
    logic [2:0] monSync_q;
    logic [2:0] pdSync_q;
    logic disFilt_q;
    logic monFilt_q;
    logic pdFilt_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            disSync_q <= 3'h7;
            monSync_q <= 3'h0;
            pdSync_q <= 3'h0;
            disFilt_q <= 1'b1;
            monFilt_q <= 1'b0;
            pdFilt_q <= 1'b0;
        end else begin
            disSync_q <= {disSync_q[1:0], disablePin};
            monSync_q <= {monSync_q[1:0], biasMonitorOver};
            pdSync_q <= {pdSync_q[1:0], photodiodeOver};
            if (disSync_q[1] == disSync_q[2]) disFilt_q <= disSync_q[2];
            if (monSync_q[1] == monSync_q[2]) monFilt_q <= monSync_q[2];
            if (pdSync_q[1] == pdSync_q[2]) pdFilt_q <= pdSync_q[2];
        end
    end

    // Fault detection
    logic [DAC_W-1:0] dacPrev_q;
    logic [DAC_W:0] dacNewX2;
    logic dacDrop;
    logic faultNow;
    logic disabling;

    assign dacNewX2 = {biasDacCode, 1'b0};
    assign dacDrop = biasDacUpdate && (dacNewX2 < {1'b0, dacPrev_q});
    assign faultNow = monFilt_q || pdFilt_q || dacDrop;
    assign disabling = disFilt_q || !outputEnableBit;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dacPrev_q <= '0;
        end else if (biasDacUpdate) begin
            dacPrev_q <= biasDacCode;
        end
    end

    // Safety state machine
    ldfc_state_e state_q;
    ldfc_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic pending_q;
    logic pending_d;
    logic trip;

    assign trip = faultNow && faultShutdownEnable;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pending_d = pending_q;
        case (state_q)
            LDFC_OPER: begin
                if (disabling) begin
                    state_d = LDFC_OFF;
                    cnt_d = '0;
                end else if (trip) begin
                    state_d = LDFC_TRIPPED;
                end
            end
            LDFC_TRIPPED: begin
                if (disabling) begin
                    state_d = LDFC_OFF;
                    cnt_d = '0;
                    pending_d = 1'b1;
                end
            end
            LDFC_OFF: begin
                if (cnt_q < CNT_W'(CNT_MAX)) cnt_d = cnt_q + 1'b1;
                if (cnt_q >= LATCH_LIM) pending_d = 1'b0;
                if (!disabling) begin
                    if (trip || (pending_q && cnt_q < LATCH_LIM)) begin
                        state_d = LDFC_TRIPPED;
                    end else begin
                        state_d = LDFC_WAKE;
                        cnt_d = '0;
                        pending_d = 1'b0;
                    end
                end
            end
            LDFC_WAKE: begin
                cnt_d = cnt_q + 1'b1;
                if (disabling) begin
                    state_d = LDFC_OFF;
                    cnt_d = '0;
                end else if (trip) begin
                    state_d = LDFC_TRIPPED;
                end else if (cnt_q >= NEGATE_LIM - 1'b1) begin
                    state_d = LDFC_OPER;
                end
            end
            default: begin
                state_d = LDFC_OFF;
                cnt_d = '0;
            end
        endcase
    end

    logic fault_q;
    logic zero_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= LDFC_OFF;
            cnt_q <= '0;
            pending_q <= 1'b0;
            fault_q <= 1'b0;
            zero_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pending_q <= pending_d;
            fault_q <= (state_d == LDFC_TRIPPED);
            zero_q <= (state_d != LDFC_OPER);
        end
    end

    assign regRdData = regRdData_q;
    assign trim = trim_q;
    assign biasForceZero = zero_q;
    assign modForceZero = zero_q;
    assign faultOutput = fault_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_eq_bypass: assert property (!equalizerOn |=> trim.eqBypass && trim.eqStrength == 8'h00)
        else $error("equalizer not bypassed when off");
    chk_eq_inverse: assert property (equalizerOn |=>
        !trim.eqBypass && trim.eqStrength == ~$past(equalizer_adjust_q))
        else $error("equalizer code not inverted");
    chk_cp_sign: assert property (##1 trim.crossShiftPositive == $past(cross_point_adjust_q[7]))
        else $error("cross-point sign wrong");
    chk_cp_mag: assert property (##1 trim.crossShiftMag == $past(cross_point_adjust_q[6:0]))
        else $error("cross-point magnitude wrong");
    chk_lim_sign: assert property (##1 trim.limiterLower == $past(limAdj_q[3]))
        else $error("limiter direction wrong");
    chk_lim_mag: assert property (##1 trim.limiterMag == $past(limAdj_q[2:0]))
        else $error("limiter magnitude wrong");
    chk_wide_range: assert property (##1 trim.wideModRange == $past(hmc_q[0]))
        else $error("modulation range bit wrong");
    chk_fault_sources: assert property ((monFilt_q || pdFilt_q) && faultShutdownEnable &&
        state_q == LDFC_OPER && !disabling |=> faultOutput && biasForceZero)
        else $error("monitor fault missed");
    chk_dac_drop: assert property (biasDacUpdate && biasDacCode < (dacPrev_q >> 1) &&
        faultShutdownEnable && state_q == LDFC_OPER && !disabling |=> faultOutput)
        else $error("bias DAC drop missed");
    chk_trip_zero: assert property ((state_q == LDFC_OPER && !disabling && trip) |=>
        faultOutput && biasForceZero && modForceZero)
        else $error("fault did not trip");
    chk_fault_hold: assert property ((faultOutput && !disabling) |=> faultOutput)
        else $error("fault latch dropped");
    chk_fault_low: assert property (disabling |=> !faultOutput)
        else $error("fault output high while disabled");
    chk_wake_time: assert property ($fell(zero_q) |->
        $past(state_q == LDFC_WAKE) && cnt_q >= NEGATE_LIM - 1'b1)
        else $error("resumed before negate time");
    chk_persist_trip: assert property ((state_q == LDFC_OFF && !disabling && trip) |=>
        faultOutput && zero_q)
        else $error("persisting fault not reasserted");
    chk_no_enable: assert property ((state_q == LDFC_OPER && !disabling && !faultShutdownEnable) |=>
        !faultOutput)
        else $error("fault latched with shutdown disabled");

    cov_trip: cover property (state_q == LDFC_OPER ##1 state_q == LDFC_TRIPPED);
    cov_recover: cover property (state_q == LDFC_WAKE ##1 state_q == LDFC_OPER);
    cov_retrip: cover property (state_q == LDFC_OFF && pending_q ##1 state_q == LDFC_TRIPPED);

endmodule : ldfc_core
`default_nettype wire

// ---- tb/ldfc_mcu_model.sv ----
// Microcontroller model: register port and recovery controls
`timescale 1ns/100ps
`default_nettype none
module ldfc_mcu_model (
    // Clock
    input wire logic core_clk,
    // Register port
    input wire logic [7:0] regRdData,
    output logic regWrEn,
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    // Recovery controls
    output logic outputEnableBit,
    output logic disablePin
);
    initial begin
        regWrEn = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        outputEnableBit = 1'b1;
        disablePin = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk) #2;
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge core_clk) #2;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk) #2;
        regAddr = a;
        @(posedge core_clk) #1;
        d = regRdData;
    endtask : rd
    // Enter or leave the disabling state, on the pin or on the bit
    task automatic hold(input bit pin, input bit on);
        @(posedge core_clk) #2;
        disablePin = pin & on;
        outputEnableBit = pin | !on;
    endtask : hold
endmodule : ldfc_mcu_model
`default_nettype wire

// ---- tb/ldfc_core_tb.sv ----
// Self-checking bench for trim decode and fault logic
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module ldfc_core_tb import ldfc_pkg::*;;
    localparam int LAT = 20;
    localparam int NEG = 12;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic equalizerOn = 1'b0;
    logic faultShutdownEnable = 1'b0;
    logic biasMonitorOver = 1'b0;
    logic photodiodeOver = 1'b0;
    logic biasDacUpdate = 1'b0;
    logic [9:0] biasDacCode = 10'h000;
    logic regWrEn, outputEnableBit, disablePin;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, rdv;
    ldfc_trim_s trim;
    logic biasForceZero, modForceZero, faultOutput;
    logic [31:0] seed = 32'he5fc;
    int num_errors = 0;
    int cmp_count = 0;
    int regM [4] = '{0, 0, 0, 0};
    always #12.5 core_clk = ~core_clk;
    ldfc_core #(.LATCH_RESET_CYC(LAT), .NEGATE_CYC(NEG), .DAC_W(10)) i_ldfc_core (
        .core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .equalizerOn(equalizerOn),
        .faultShutdownEnable(faultShutdownEnable), .outputEnableBit(outputEnableBit),
        .disablePin(disablePin), .biasMonitorOver(biasMonitorOver), .photodiodeOver(photodiodeOver),
        .biasDacUpdate(biasDacUpdate), .biasDacCode(biasDacCode), .trim(trim),
        .biasForceZero(biasForceZero), .modForceZero(modForceZero), .faultOutput(faultOutput));
    ldfc_mcu_model i_ldfc_mcu_model (.core_clk(core_clk), .regRdData(regRdData), .regWrEn(regWrEn),
        .regAddr(regAddr), .regWrData(regWrData), .outputEnableBit(outputEnableBit), .disablePin(disablePin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // Wait bounded for the fault line or the zero forcing
    task automatic waitFor(input bit zero, input logic v, input int maxC);
        for (int n = 0; n < maxC && (zero ? biasForceZero : faultOutput) !== v; n++) begin
            @(posedge core_clk) #1;
        end
        `CK("faultOrZero", v, zero ? biasForceZero : faultOutput);
        `CK("modForceZero", biasForceZero, modForceZero);
    endtask : waitFor
    task automatic dac(input logic [9:0] c);
        @(posedge core_clk) #2;
        biasDacUpdate = 1'b1;
        biasDacCode = c;
        @(posedge core_clk) #2;
        biasDacUpdate = 1'b0;
    endtask : dac
    task automatic chkTrim();
        `CK("eqBypass", !equalizerOn, trim.eqBypass);
        if (equalizerOn) `CK("eqStrength", 8'(~regM[0]), trim.eqStrength);
        `CK("cpSign", regM[1][7], trim.crossShiftPositive);
        `CK("cpMag", 7'(regM[1]), trim.crossShiftMag);
        `CK("limSign", regM[2][3], trim.limiterLower);
        `CK("limMag", 3'(regM[2]), trim.limiterMag);
        `CK("wideRange", regM[3][0], trim.wideModRange);
    endtask : chkTrim
    // Full disable and clean re-enable
    task automatic rec(input bit pin);
        i_ldfc_mcu_model.hold(pin, 1'b1);
        waitFor(0, 1'b0, 8);
        repeat (LAT + 4) @(posedge core_clk);
        i_ldfc_mcu_model.hold(pin, 1'b0);
        repeat (NEG - 1) @(posedge core_clk);
        #1;
        waitFor(1, 1'b1, 0);
        waitFor(1, 1'b0, 12);
        waitFor(0, 1'b0, 0);
    endtask : rec
    initial begin
        #(25 * 4000);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        summarize();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        #2 rst = 1'b0;
        waitFor(1, 1'b0, NEG + 12);
        for (int i = 0; i < 25; i++) begin
            rdv = (i < 5) ? 8'hff : (i < 10) ? 8'h00 : 8'(rnd());
            @(posedge core_clk) #2;
            equalizerOn = (i < 10) ? i[1] : rdv[3];
            i_ldfc_mcu_model.wr(4'(6 + i % 5), rdv);
            if (i % 5 < 4) regM[i % 5] = rdv;
            @(posedge core_clk) #1;
            chkTrim();
            i_ldfc_mcu_model.rd(4'(6 + i % 5), rdv);
            `CK("readback", (i % 5 < 4) ? 8'(regM[i % 5]) : 8'h00, rdv);
        end
        #1 photodiodeOver = 1'b1;
        dac(10'h190);
        dac(10'h064);
        repeat (8) @(posedge core_clk);
        #1;
        waitFor(0, 1'b0, 0);
        waitFor(1, 1'b0, 0);
        #1 photodiodeOver = 1'b0;
        repeat (6) @(posedge core_clk);
        #2 faultShutdownEnable = 1'b1;
        dac(10'h0c8);
        dac(10'h064);
        repeat (6) @(posedge core_clk);
        #1;
        waitFor(0, 1'b0, 0);
        dac(10'h031);
        waitFor(0, 1'b1, 4);
        waitFor(1, 1'b1, 0);
        i_ldfc_mcu_model.hold(1, 1'b1);
        waitFor(0, 1'b0, 8);
        repeat (LAT / 2) @(posedge core_clk);
        i_ldfc_mcu_model.hold(1, 1'b0);
        waitFor(0, 1'b1, 8);
        rec(1);
        chkTrim();
        #1 biasMonitorOver = 1'b1;
        waitFor(0, 1'b1, 8);
        #1 biasMonitorOver = 1'b0;
        photodiodeOver = 1'b1;
        i_ldfc_mcu_model.hold(0, 1'b1);
        waitFor(0, 1'b0, 4);
        repeat (LAT + 4) @(posedge core_clk);
        i_ldfc_mcu_model.hold(0, 1'b0);
        waitFor(0, 1'b1, 3);
        repeat (NEG + 4) @(posedge core_clk);
        #1;
        waitFor(1, 1'b1, 0);
        #1 photodiodeOver = 1'b0;
        repeat (6) @(posedge core_clk);
        rec(0);
        summarize();
    end
endmodule : ldfc_core_tb
`default_nettype wire
